// ### shared/lpst_pkg.sv
package lpst_pkg;

    // =====================================================================
    // widths
    localparam int LANES      = 4;
    localparam int BITS_LANE  = 7;
    localparam int WORD_W     = 28;
    localparam int FIFO_DEPTH = 4;

    // =====================================================================
    // timing
    localparam int CLK_HZ          = 40000000;
    localparam int LOCK_TIME_US    = 1;
    // least time, rounded down to whole cycles by integer division
    localparam int LOCK_CYCLES     = (LOCK_TIME_US * (CLK_HZ / 1000000) + 0);
    localparam int LOCK_CNT_W      = 16;
    localparam int PERIOD_CNT_W    = 12;
    localparam int MAX_PERIOD      = 4095;
    localparam int SLOT_W          = 3;
    localparam int HALF_CLK_SLOT   = 3;
    localparam int FRAC_W          = 16;

    // =====================================================================
    // states
    typedef enum logic [2:0]
    {
        LPST_OFF    = 3'b001,
        LPST_LOCK   = 3'b010,
        LPST_RUN    = 3'b100
    } lpst_state_t;

endpackage

// ### logic/lpst_fifo.sv
`timescale 1ns/100ps

module lpst_fifo
#(
    parameter int WIDTH = 28,
    parameter int DEPTH = 4
)
(
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    input  wire logic             clear_i,
    input  wire logic [WIDTH-1:0] wdata_i,
    input  wire logic             wvalid_i,
    output logic                  wready_o,
    output logic      [WIDTH-1:0] rdata_o,
    output logic                  rvalid_o,
    input  wire logic             rready_i
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed
    {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } lpst_fifo_st_t;

    lpst_fifo_st_t st;
    lpst_fifo_st_t next_st;
    logic          push;
    logic          pop;

    // =====================================================================
    // handshakes
    assign wready_o = (st.cnt != (AW+1)'(DEPTH));
    assign rvalid_o = (st.cnt != '0);
    assign rdata_o  = st.mem[st.rp];
    assign push     = wvalid_i && wready_o;
    assign pop      = rready_i && rvalid_o;

    // next state; clear drops everything held
    always_comb
    begin
        next_st = st;
        if (push)
        begin
            next_st.mem[st.wp] = wdata_i;
            next_st.wp         = (st.wp == AW'(DEPTH-1)) ? '0 : st.wp + 1'b1;
        end
        if (pop)
            next_st.rp = (st.rp == AW'(DEPTH-1)) ? '0 : st.rp + 1'b1;
        next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
        if (clear_i)
            next_st = '0;
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            st <= '0;
        else
            st <= next_st;
    end

endmodule

// ### logic/lpst_tx.sv
`timescale 1ns/100ps

// What this block does
// - Four independent 7-bit registers each load in parallel from the captured word and shift out on their own lane.
// - A serial bit slot rate of seven times the pixel clock is derived, one slot per register bit each pixel period.
// - Each pixel period carries 28 input bits over five output pairs, four data and one clock.
// - Every input bit 0 through 27 is captured on the selected pixel clock edge.
// - Edge select high captures on the rising edge, low on the falling edge.
// - While shutdown is low the internal clocking stops and all pair drivers are off.
// - Shutdown low forces every internal register but the input syncs, shift registers included, to zero; the state machine goes to OFF.

module lpst_tx
(
    input  wire logic                         clk_i,
    input  wire logic                         nrst_i,
    input  wire logic                         pixel_clock_in_i,
    input  wire logic                         capture_edge_select_i,
    input  wire logic                         shutdown_clear_n_i,
    input  wire logic [lpst_pkg::WORD_W-1:0]  parallel_input_i,
    output logic      [lpst_pkg::LANES-1:0]   data_lane_o,
    output logic                              clock_lane_o,
    output logic                              driver_enable_o,
    output logic                              link_locked_o,
    output logic                              fifo_overflow_o
);

    // =====================================================================
    // state
    typedef struct packed
    {
        logic [1:0]                                   pclk_sync;
        logic [1:0]                                   edge_sync;
        logic [1:0]                                   shdn_sync;
        logic                                         pclk_prev;
        logic [lpst_pkg::WORD_W-1:0]                  din_s1;
        logic [lpst_pkg::WORD_W-1:0]                  din_s2;
        lpst_pkg::lpst_state_t                        fsm;
        logic [lpst_pkg::PERIOD_CNT_W-1:0]            period_cnt;
        logic [lpst_pkg::PERIOD_CNT_W-1:0]            period;
        logic                                         period_ok;
        logic [lpst_pkg::FRAC_W-1:0]                  phase;
        logic [lpst_pkg::SLOT_W-1:0]                  slot;
        logic [lpst_pkg::LOCK_CNT_W-1:0]              lock_cnt;
        logic [lpst_pkg::LANES-1:0][lpst_pkg::BITS_LANE-1:0] shreg;
        logic [lpst_pkg::LANES-1:0]                   lane;
        logic                                         clk_lane;
        logic                                         drv_en;
        logic                                         locked;
        logic                                         ovf;
    } lpst_st_t;

    lpst_st_t                    st;
    lpst_st_t                    next_st;
    logic                        pclk_rise;
    logic                        pclk_fall;
    logic                        cap_edge;
    logic                        run;
    logic                        fifo_wready;
    logic                        fifo_rvalid;
    logic [lpst_pkg::WORD_W-1:0] fifo_rdata;
    logic                        load;
    logic [lpst_pkg::FRAC_W:0]   phase_sum;
    logic [lpst_pkg::FRAC_W-1:0] step;

    // =====================================================================
    // edge detection on the twice-synced pixel clock
    assign pclk_rise = st.pclk_sync[1] && !st.pclk_prev;
    assign pclk_fall = !st.pclk_sync[1] && st.pclk_prev;
    assign cap_edge  = st.edge_sync[1] ? pclk_rise : pclk_fall;
    assign run       = st.shdn_sync[1];

    // slot pulse at 7x pixel rate: phase accumulator step = 7*2^16/period
    assign step      = (st.period_ok && st.period != '0)
                     ? lpst_pkg::FRAC_W'((32'(lpst_pkg::BITS_LANE) << lpst_pkg::FRAC_W) / 32'(st.period))
                     : '0;
    assign phase_sum = {1'b0, st.phase} + {1'b0, step};

    // a word loads into the shifters at the start of each seven-slot group
    assign load      = (st.fsm != lpst_pkg::LPST_OFF) && phase_sum[lpst_pkg::FRAC_W]
                     && (st.slot == lpst_pkg::SLOT_W'(lpst_pkg::BITS_LANE - 1));

    // captured words wait here; slack absorbs jitter between the edge and the slot grid
    lpst_fifo
    #(
        .WIDTH (lpst_pkg::WORD_W),
        .DEPTH (lpst_pkg::FIFO_DEPTH)
    )
    u_fifo
    (
        .clk_i    (clk_i),
        .nrst_i   (nrst_i),
        .clear_i  (!run),
        .wdata_i  (st.din_s2),
        .wvalid_i (run && cap_edge),
        .wready_o (fifo_wready),
        .rdata_o  (fifo_rdata),
        .rvalid_o (fifo_rvalid),
        .rready_i (load)
    );

    // =====================================================================
    // next state
    always_comb
    begin
        next_st              = st;
        next_st.pclk_sync    = {st.pclk_sync[0], pixel_clock_in_i};
        next_st.edge_sync    = {st.edge_sync[0], capture_edge_select_i};
        next_st.shdn_sync    = {st.shdn_sync[0], shutdown_clear_n_i};
        next_st.din_s1       = parallel_input_i;
        next_st.din_s2       = st.din_s1;  // all 28 bits, aligned with the clock sync
        next_st.pclk_prev    = st.pclk_sync[1];

        // pixel period measured between rising edges
        if (pclk_rise)
        begin
            next_st.period     = st.period_cnt;
            next_st.period_ok  = (st.period_cnt != '0);
            next_st.period_cnt = lpst_pkg::PERIOD_CNT_W'(1);
        end
        else if (st.period_cnt != lpst_pkg::PERIOD_CNT_W'(lpst_pkg::MAX_PERIOD))
            next_st.period_cnt = st.period_cnt + 1'b1;
        else
            next_st.period_ok  = 1'b0;  // pixel clock stalled

        // slot generator
        next_st.phase = phase_sum[lpst_pkg::FRAC_W-1:0];
        if (phase_sum[lpst_pkg::FRAC_W])
        begin
            if (st.slot == lpst_pkg::SLOT_W'(lpst_pkg::BITS_LANE - 1))
                next_st.slot = '0;
            else
                next_st.slot = st.slot + 1'b1;
            // shift out lsb first; load on group boundary
            for (int i = 0; i < lpst_pkg::LANES; i++)
            begin
                if (load)
                begin
                    next_st.shreg[i] = fifo_rvalid ? fifo_rdata[i*lpst_pkg::BITS_LANE +: lpst_pkg::BITS_LANE] : '0;
                    next_st.lane[i]  = next_st.shreg[i][0];
                    next_st.shreg[i] = next_st.shreg[i] >> 1;
                end
                else
                begin
                    next_st.lane[i]  = st.shreg[i][0];
                    next_st.shreg[i] = st.shreg[i] >> 1;
                end
            end
            // clock pair high for slots 3 to 5 of each group, low for slots 0 to 2 and 6
            next_st.clk_lane = (next_st.slot < lpst_pkg::SLOT_W'(lpst_pkg::HALF_CLK_SLOT))
                            || (next_st.slot == lpst_pkg::SLOT_W'(lpst_pkg::BITS_LANE - 1)) ? 1'b0 : 1'b1;
        end

        if (cap_edge && run && !fifo_wready)
            next_st.ovf = 1'b1;

        // lock sequence
        case (st.fsm)
            lpst_pkg::LPST_OFF:
            begin
                next_st.fsm = lpst_pkg::LPST_LOCK;
            end
            lpst_pkg::LPST_LOCK:
            begin
                next_st.drv_en = 1'b1;
                if (!st.period_ok)
                    next_st.lock_cnt = '0;
                else if (st.lock_cnt == lpst_pkg::LOCK_CNT_W'(lpst_pkg::LOCK_CYCLES))
                begin
                    next_st.fsm    = lpst_pkg::LPST_RUN;
                    next_st.locked = 1'b1;
                end
                else
                    next_st.lock_cnt = st.lock_cnt + 1'b1;
            end
            lpst_pkg::LPST_RUN:
            begin
                // output stays invalid until the slot grid tracks the pixel clock
                if (!st.period_ok)
                begin
                    next_st.fsm      = lpst_pkg::LPST_LOCK;
                    next_st.locked   = 1'b0;
                    next_st.lock_cnt = '0;
                end
            end
            default:
            begin
                next_st.fsm = lpst_pkg::LPST_OFF;
            end
        endcase

        // shutdown stops clocking, drivers off, all registers cleared; syncs keep running
        if (!run)
        begin
            next_st           = '0;
            next_st.fsm       = lpst_pkg::LPST_OFF;
            next_st.pclk_sync = {st.pclk_sync[0], pixel_clock_in_i};
            next_st.edge_sync = {st.edge_sync[0], capture_edge_select_i};
            next_st.shdn_sync = {st.shdn_sync[0], shutdown_clear_n_i};
        end
    end

    // =====================================================================
    // registers
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            st     <= '0;
            st.fsm <= lpst_pkg::LPST_OFF;
        end
        else
            st <= next_st;
    end

    // outputs from flip-flops
    assign data_lane_o     = st.lane;
    assign clock_lane_o    = st.clk_lane;
    assign driver_enable_o = st.drv_en;
    assign link_locked_o   = st.locked;
    assign fifo_overflow_o = st.ovf;

endmodule

// ### test/lpst_tx_assertions.sv
`timescale 1ns/100ps

// =========================================================
// pin level checks of the transmitter
module lpst_tx_assertions
(
    input  wire logic                        clk_i,
    input  wire logic                        nrst_i,
    input  wire logic                        pixel_clock_in_i,
    input  wire logic                        capture_edge_select_i,
    input  wire logic                        shutdown_clear_n_i,
    input  wire logic [lpst_pkg::WORD_W-1:0] parallel_input_i,
    input  wire logic [lpst_pkg::LANES-1:0]  data_lane_o,
    input  wire logic                        clock_lane_o,
    input  wire logic                        driver_enable_o,
    input  wire logic                        link_locked_o,
    input  wire logic                        fifo_overflow_o
);
    localparam int LOCK_MIN = lpst_pkg::LOCK_CYCLES - 1;
    logic [6:0] en_cnt;

    // cycles since the drivers came on, saturating so it never wraps
    always_ff @(posedge clk_i or negedge nrst_i)
        if (!nrst_i)
            en_cnt <= 7'h00;
        else if (!driver_enable_o)
            en_cnt <= 7'h00;
        else if (en_cnt != 7'h7F)
            en_cnt <= en_cnt + 7'h01;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // =========================================================
    // shutdown and lock
    drv_off_a: assert property (!shutdown_clear_n_i [*4] |-> !driver_enable_o)
        else $error("drivers on during shutdown");
    regs_clear_a: assert property (!shutdown_clear_n_i [*4] |->
        data_lane_o == '0 && !clock_lane_o && !link_locked_o && !fifo_overflow_o)
        else $error("state not cleared by shutdown");
    idle_quiet_a: assert property (!driver_enable_o |-> data_lane_o == '0 && !clock_lane_o)
        else $error("pairs toggle while drivers off");
    lock_late_a: assert property ($rose(link_locked_o) |-> en_cnt >= LOCK_MIN)
        else $error("lock flagged too early");
    lock_soon_a: assert property (disable iff (!nrst_i || !shutdown_clear_n_i)
        $rose(driver_enable_o) |-> ##[40:160] link_locked_o)
        else $error("lock not reached");
    lock_drv_a: assert property (link_locked_o |-> driver_enable_o)
        else $error("locked while drivers off");

    // =========================================================
    // clock pair framing, bench pixel period of 8 cycles
    clk_high_a: assert property (disable iff (!nrst_i || !shutdown_clear_n_i)
        link_locked_o && $rose(clock_lane_o) |-> clock_lane_o [*3] ##[1:3] !clock_lane_o)
        else $error("clock pair high time wrong");
    clk_rate_a: assert property (disable iff (!nrst_i || !shutdown_clear_n_i)
        link_locked_o && $rose(clock_lane_o) |-> ##1 (!$rose(clock_lane_o)) [*6] ##[1:3] $rose(clock_lane_o))
        else $error("clock pair period wrong");
endmodule

bind lpst_tx lpst_tx_assertions u_chk
(
    .clk_i(clk_i), .nrst_i(nrst_i), .pixel_clock_in_i(pixel_clock_in_i),
    .capture_edge_select_i(capture_edge_select_i), .shutdown_clear_n_i(shutdown_clear_n_i),
    .parallel_input_i(parallel_input_i), .data_lane_o(data_lane_o), .clock_lane_o(clock_lane_o),
    .driver_enable_o(driver_enable_o), .link_locked_o(link_locked_o), .fifo_overflow_o(fifo_overflow_o)
);

// ### test/lpst_rx_model.sv
`timescale 1ns/100ps

// =========================================================
// panel receiver: slot starts seen as changes on clock pair and marker lanes
module lpst_rx_model
(
    input  wire logic                       clk_i,
    input  wire logic                       locked_i,
    input  wire logic [lpst_pkg::LANES-1:0] lane_i,
    input  wire logic                       clk_lane_i
);
    logic [27:0] words[$];
    logic [27:0] acc;
    logic [2:0]  prev = 3'h0;
    int          idx  = 0;

    // falling clock pair opens slot 6, closing the group
    always @(posedge clk_i)
    begin
        if (locked_i && {clk_lane_i, lane_i[3:2]} != prev)
        begin
            if (prev[2] && !clk_lane_i)
            begin
                for (int l = 0; l < 4; l++)
                    acc[7*l+6] = lane_i[l];
                if (idx == 6)
                    words.push_back(acc);
                idx = 0;
            end
            else if (idx < 6)
            begin
                for (int l = 0; l < 4; l++)
                    acc[7*l+idx] = lane_i[l]; // lane l holds bits 7l..7l+6, first bit first
                idx++;
            end
        end
        prev = {clk_lane_i, lane_i[3:2]};
    end
endmodule

// ### test/tb_lvds_pixel_serializer_tx.sv
`timescale 1ns/100ps

module tb_lvds_pixel_serializer_tx;
    localparam int N = 24;
    logic        clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        pixel_clock_in_i = 1'b0;
    logic        capture_edge_select_i = 1'b1;
    logic        shutdown_clear_n_i = 1'b0; // held low from power-up
    logic [27:0] parallel_input_i = '0;
    logic [3:0]  data_lane_o;
    logic        clock_lane_o;
    logic        driver_enable_o;
    logic        link_locked_o;
    logic        fifo_overflow_o;
    logic        run = 1'b0;
    int          ph = 0;
    int          k = 0;
    int          n_fail = 0;
    int          checked = 0;

    lpst_tx dut
    (
        .clk_i(clk_i), .nrst_i(nrst_i), .pixel_clock_in_i(pixel_clock_in_i),
        .capture_edge_select_i(capture_edge_select_i), .shutdown_clear_n_i(shutdown_clear_n_i),
        .parallel_input_i(parallel_input_i), .data_lane_o(data_lane_o), .clock_lane_o(clock_lane_o),
        .driver_enable_o(driver_enable_o), .link_locked_o(link_locked_o), .fifo_overflow_o(fifo_overflow_o)
    );
    lpst_rx_model rx
    (
        .clk_i(clk_i), .locked_i(link_locked_o), .lane_i(data_lane_o), .clk_lane_i(clock_lane_o)
    );

    always #12.5 clk_i = ~clk_i;

    // lane 3 alternates and lane 2 ends differ, so the panel model sees every slot;
    // bits 0, 7 and 15 tied high as a 12-bit host on an 18-bit panel would
    function automatic logic [27:0] wgen(input int i);
        logic [6:0] v;
        v = 7'(i * 37 + 5);
        return {7'h55, 1'b1, v[4:1], 2'b10, ~v[6:1], 1'b1, v[6:1] ^ 6'h15, 1'b1};
    endfunction

    // =========================================================
    // pixel source: 200 ns period, word changes on the edge not captured
    always @(posedge clk_i)
    begin
        ph <= (ph == 3) ? 0 : ph + 1;
        if (ph == 3)
        begin
            pixel_clock_in_i <= ~pixel_clock_in_i;
            if (pixel_clock_in_i == capture_edge_select_i)
            begin
                parallel_input_i <= (run && k < N) ? wgen(k) : '0; // black outside real data
                k <= run ? k + int'(k < N) : 0;
            end
        end
    end

    // =========================================================
    // checking and verdict
    task automatic chk(input string what, input logic [27:0] seen, input logic [27:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        if (n_fail == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // shutdown, pick the edge, relock, then a burst of words through the link
    task automatic t_stream(input logic sel);
        int p;
        shutdown_clear_n_i <= 1'b0;
        repeat (10) @(posedge clk_i); // source kept up 250 ns after shutdown
        capture_edge_select_i <= sel;
        shutdown_clear_n_i <= 1'b1;
        rx.words.delete();
        repeat (20) @(posedge clk_i);
        chk("drivers on", driver_enable_o, 1);
        chk("early lock", link_locked_o, 0);
        for (int i = 0; i < 400 && link_locked_o !== 1'b1; i++)
            @(posedge clk_i);
        chk("locked", link_locked_o, 1);
        run <= 1'b1;
        while (k < N)
            @(posedge clk_i);
        repeat (40) @(posedge clk_i);
        run <= 1'b0;
        p = -1;
        foreach (rx.words[j])
            if (p < 0 && rx.words[j] === wgen(0))
                p = j;
        for (int i = 0; i < N; i++)
            chk("rx word", rx.words[p+i], wgen(i));
        chk("overflow", fifo_overflow_o, 0);
    endtask

    // shutdown in mid-burst must blank and clear everything within five cycles
    task automatic t_abort();
        // the word counter only clears on a source data edge, so let a few pass first
        repeat (20) @(posedge clk_i);
        chk("still locked", link_locked_o, 1);
        run <= 1'b1;
        while (k < 8)
            @(posedge clk_i);
        shutdown_clear_n_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        chk("drivers off", driver_enable_o, 0);
        chk("outputs", {data_lane_o, clock_lane_o, link_locked_o, fifo_overflow_o}, 0);
        run <= 1'b0;
    endtask

    initial
    begin
        repeat (4) @(posedge clk_i);
        nrst_i <= 1'b1;
        t_stream(1'b1);
        t_stream(1'b0);
        t_abort();
        results();
    end

    // watchdog, more than ten times the expected run
    initial
    begin
        #200us;
        n_fail++;
        results();
    end
endmodule
